// ---- iepf_pkg.sv ----
// package for the interrupt edge/priority control and second event flag register
// assumes one clock domain and a plain strobe register port
package iepf_pkg;
  // register offsets
  localparam logic [3:0] OFS_EDGE_PRIO_CTRL = 4'h0;
  localparam logic [3:0] OFS_EVENT_FLAGS = 4'h1;
  localparam logic [3:0] OFS_EVENT_MASK = 4'h2;
  localparam logic [3:0] OFS_PULLUP_A = 4'h3;
  localparam logic [3:0] OFS_PULLUP_B = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  localparam logic [3:0] OFS_NV_CTRL = 4'h6;
  // control register fields
  localparam int BIT_PULLUP_MASTER_DISABLE = 7;
  localparam int BIT_EDGE0 = 6;
  localparam int BIT_EDGE1 = 5;
  localparam int BIT_EDGE2 = 4;
  localparam int BIT_TMR0_PRIO = 2;
  localparam int BIT_PORT_CHG_PRIO = 0;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'hF5;
  localparam logic [7:0] CTRL_RESET = 8'hF5;
  // flag register fields
  localparam int BIT_OSC_FAIL = 7;
  localparam int BIT_CMP1 = 6;
  localparam int BIT_CMP2 = 5;
  localparam int BIT_NV_DONE = 4;
  localparam int BIT_BUS_COLL = 3;
  localparam int BIT_TMR3 = 1;
  localparam logic [7:0] FLAG_IMPL_MASK = 8'hFA;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  // status register fields
  localparam int BIT_ST_RUN_MODE = 0;
  localparam int BIT_ST_WIP = 1;
  // nv control: write of this bit starts a write cycle
  localparam int BIT_NV_START = 0;
  localparam int NV_WRITE_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iepf_req_t;

  // peripheral event inputs
  typedef struct packed {
    logic clk_fail;
    logic cmp1_change;
    logic cmp2_change;
    logic bus_collision;
    logic tmr3_overflow;
  } iepf_evt_t;
endpackage

// ---- iepf_edge_detect.sv ----
// per-input selectable edge detector for the external interrupt pins
// assumes inputs synchronous to ref_clk_i
`timescale 1ns/1ps
module iepf_edge_detect #(
  parameter int N = 3
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [N-1:0] pin_i,
  input wire logic [N-1:0] rising_sel_i,
  output logic [N-1:0] edge_o
);
  initial begin
    if (N < 1) $error("N must be at least 1");
  end
  logic [N-1:0] prev;
  logic [N-1:0] next_prev;
  // next sample
  always_comb begin
    next_prev = pin_i;
  end
  // sample register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) prev <= '0;
    else prev <= next_prev;
  end
  // choose rising or falling edge per input
  for (genvar g = 0; g < N; g++) begin : g_edge
    assign edge_o[g] = rising_sel_i[g] ? (pin_i[g] & ~prev[g]) : (~pin_i[g] & prev[g]); // [R01]
  end
endmodule // iepf_edge_detect

// ---- iepf_top.sv ----
// interrupt edge/priority control, pull-up gating and second peripheral flag register
// assumes synchronous inputs, a one-cycle strobe register port and a 25 MHz clock
// How it works
// R01: each external interrupt input has its own rising or falling edge select bit
// R02: master pull-up bit set disables all pull-ups; clear gives per-pin input pull-ups
// R03: timer-0 overflow priority bit picks high or low priority level
// R04: port change priority bit picks high or low priority level
// R05: flags set on their event whatever the mask says; the clock fail flag also needs the monitor enable
// R06: clock failure with monitor enabled forces internal run mode and sets fail flag
// R07: nonvolatile write completion sets the write-done flag
// R08: bus collision sets its flag, held until software clears it
// R09: write end clears the in-progress bit and sets the done flag
// R10: flags clear only by software writing zero; unimplemented bits read zero
`timescale 1ns/1ps
module iepf_top
  import iepf_pkg::*;
#(
  parameter int N_EXT = 3,
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire iepf_req_t req_i,
  output logic [7:0] rdata_o,
  input wire logic [N_EXT-1:0] ext_irq_pin_i,
  output logic [N_EXT-1:0] ext_irq_event_o,
  input wire iepf_evt_t evt_i,
  input wire logic fail_safe_enable_i,
  input wire logic timer_zero_overflow_i,
  input wire logic port_change_i,
  input wire logic [7:0] port_a_input_mode_i,
  input wire logic [7:0] port_b_input_mode_i,
  output logic [7:0] port_a_pullup_on_o,
  output logic [7:0] port_b_pullup_on_o,
  output logic internal_osc_run_mode_o,
  output logic timer_zero_hi_prio_o,
  output logic timer_zero_lo_prio_o,
  output logic port_change_hi_prio_o,
  output logic port_change_lo_prio_o,
  output logic irq_o
);
  initial begin
    if (N_EXT != 3) $error("three external inputs are mapped in the control register");
    if (NV_CYCLES < 1) $error("NV_CYCLES must be at least 1");
    if (NV_CYCLES > 299) $error("NV_CYCLES must fit the done flag check window");
  end

  localparam int CW = $clog2(NV_CYCLES + 1);
  // the done flag shows one cycle after the count reaches zero
  localparam int NV_DONE_DELAY = NV_CYCLES + 1;

  // register state
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] flags, next_flags;
  logic [7:0] mask, next_mask;
  logic [7:0] pu_a, next_pu_a;
  logic [7:0] pu_b, next_pu_b;
  logic run_mode, next_run_mode;
  logic [7:0] rdata, next_rdata;

  // write cycle state machine
  typedef enum logic [0:0] {
    NV_IDLE = 1'b0,
    NV_BUSY = 1'b1
  } iepf_nv_state_t;
  iepf_nv_state_t nv_state, next_nv_state;
  logic [CW-1:0] nv_cnt, next_nv_cnt;
  logic nv_done;

  logic wr_ctrl, wr_flags, wr_mask, wr_pu_a, wr_pu_b, wr_nv;
  logic [2:0] edge_sel;
  logic [7:0] evt_set;

  // decode of write strobes
  // an unmapped offset matches no strobe, so such a write is simply dropped
  assign wr_ctrl = req_i.wr && (req_i.addr == OFS_EDGE_PRIO_CTRL);
  assign wr_flags = req_i.wr && (req_i.addr == OFS_EVENT_FLAGS);
  assign wr_mask = req_i.wr && (req_i.addr == OFS_EVENT_MASK);
  assign wr_pu_a = req_i.wr && (req_i.addr == OFS_PULLUP_A);
  assign wr_pu_b = req_i.wr && (req_i.addr == OFS_PULLUP_B);
  assign wr_nv = req_i.wr && (req_i.addr == OFS_NV_CTRL);

  // external edge selects from the control register
  assign edge_sel = {ctrl[BIT_EDGE2], ctrl[BIT_EDGE1], ctrl[BIT_EDGE0]}; // [R01]

  iepf_edge_detect #(
    .N(N_EXT)
  ) u_edge (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .pin_i(ext_irq_pin_i),
    .rising_sel_i(edge_sel),
    .edge_o(ext_irq_event_o)
  );

  // nonvolatile write cycle timing
  // a start while busy is ignored so a running write keeps its full time
  // the done pulse comes in the cycle the count reaches zero
  always_comb begin
    next_nv_state = nv_state;
    next_nv_cnt = nv_cnt;
    nv_done = 1'b0;
    unique case (nv_state)
      NV_IDLE: begin
        if (wr_nv && req_i.wdata[BIT_NV_START]) begin
          next_nv_state = NV_BUSY;
          next_nv_cnt = CW'(NV_CYCLES - 1);
        end
      end
      NV_BUSY: begin
        if (nv_cnt == '0) begin
          next_nv_state = NV_IDLE; // [R09]
          nv_done = 1'b1;
        end else begin
          next_nv_cnt = nv_cnt - CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      nv_state <= NV_IDLE;
      nv_cnt <= '0;
    end else begin
      nv_state <= next_nv_state;
      nv_cnt <= next_nv_cnt;
    end
  end

  // event sources gathered in flag layout
  always_comb begin
    evt_set = 8'h00;
    evt_set[BIT_OSC_FAIL] = fail_safe_enable_i & evt_i.clk_fail; // [R06]
    evt_set[BIT_CMP1] = evt_i.cmp1_change;
    evt_set[BIT_CMP2] = evt_i.cmp2_change;
    evt_set[BIT_NV_DONE] = nv_done; // [R07] [R09]
    evt_set[BIT_BUS_COLL] = evt_i.bus_collision; // [R08]
    evt_set[BIT_TMR3] = evt_i.tmr3_overflow;
  end

  // register next values: software writes, then hardware set wins
  // an event in the same cycle as a zero write leaves the flag set, so none is lost
  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_pu_a = pu_a;
    next_pu_b = pu_b;
    next_run_mode = run_mode;
    next_flags = flags;
    if (wr_ctrl) next_ctrl = req_i.wdata & CTRL_IMPL_MASK;
    if (wr_mask) next_mask = req_i.wdata & FLAG_IMPL_MASK;
    if (wr_pu_a) next_pu_a = req_i.wdata;
    if (wr_pu_b) next_pu_b = req_i.wdata;
    // writing zero clears a flag, writing one leaves it
    if (wr_flags) next_flags = flags & req_i.wdata; // [R10]
    // sets regardless of mask; only the clock fail flag also needs the monitor enable
    next_flags = (next_flags | evt_set) & FLAG_IMPL_MASK; // [R05] [R08]
    if (fail_safe_enable_i && evt_i.clk_fail) next_run_mode = 1'b1; // [R06]
  end

  // read mux, data one cycle after the strobe
  // with no read strobe the port returns zero, so stale data never lingers
  always_comb begin
    next_rdata = 8'h00;
    if (req_i.rd) begin
      unique case (req_i.addr)
        OFS_EDGE_PRIO_CTRL: next_rdata = ctrl & CTRL_IMPL_MASK;
        OFS_EVENT_FLAGS: next_rdata = flags & FLAG_IMPL_MASK; // [R10]
        OFS_EVENT_MASK: next_rdata = mask;
        OFS_PULLUP_A: next_rdata = pu_a;
        OFS_PULLUP_B: next_rdata = pu_b;
        OFS_STATUS: begin
          next_rdata[BIT_ST_RUN_MODE] = run_mode;
          next_rdata[BIT_ST_WIP] = (nv_state == NV_BUSY);
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl <= CTRL_RESET;
      flags <= FLAG_RESET;
      mask <= MASK_RESET;
      pu_a <= PULLUP_RESET;
      pu_b <= PULLUP_RESET;
      run_mode <= 1'b0;
      rdata <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      flags <= next_flags;
      mask <= next_mask;
      pu_a <= next_pu_a;
      pu_b <= next_pu_b;
      run_mode <= next_run_mode;
      rdata <= next_rdata;
    end
  end

  // outputs
  // irq is a level: it falls only when software clears or masks the flag
  assign rdata_o = rdata;
  assign internal_osc_run_mode_o = run_mode;
  assign irq_o = |(flags & mask);
  // pull-up gating per pin
  assign port_a_pullup_on_o = ctrl[BIT_PULLUP_MASTER_DISABLE] ? 8'h00 :
                              (pu_a & port_a_input_mode_i); // [R02]
  assign port_b_pullup_on_o = ctrl[BIT_PULLUP_MASTER_DISABLE] ? 8'h00 :
                              (pu_b & port_b_input_mode_i); // [R02]
  // priority steering
  assign timer_zero_hi_prio_o = timer_zero_overflow_i & ctrl[BIT_TMR0_PRIO]; // [R03]
  assign timer_zero_lo_prio_o = timer_zero_overflow_i & ~ctrl[BIT_TMR0_PRIO]; // [R03]
  assign port_change_hi_prio_o = port_change_i & ctrl[BIT_PORT_CHG_PRIO]; // [R04]
  assign port_change_lo_prio_o = port_change_i & ~ctrl[BIT_PORT_CHG_PRIO]; // [R04]

  // assertions
  sequence s_nv_start;
    wr_nv && req_i.wdata[BIT_NV_START] && nv_state == NV_IDLE;
  endsequence
  sequence s_nv_end;
    nv_state == NV_BUSY && nv_cnt == '0;
  endsequence

  // the done flag stands exactly when the programmed write time is over
  a_nv_done_flag: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R07]
    s_nv_start |-> ##NV_DONE_DELAY flags[BIT_NV_DONE])
    else $error("write done flag not set after write time");

  // the last busy cycle hands over to idle with the flag raised
  a_nv_wip_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R09]
    s_nv_end |=> nv_state == NV_IDLE && flags[BIT_NV_DONE])
    else $error("write end did not clear busy and set flag");

  // a collision flag survives everything except a zero write
  a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R08]
    flags[BIT_BUS_COLL] && !(wr_flags && !req_i.wdata[BIT_BUS_COLL]) |=> flags[BIT_BUS_COLL])
    else $error("collision flag cleared without software");

  // an overflow sets its flag even with the mask clear
  a_event_sets: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R05]
    evt_i.tmr3_overflow |=> flags[BIT_TMR3])
    else $error("event did not set its flag");

  // a monitored clock failure switches mode and flags it together
  a_osc_fail: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R06]
    fail_safe_enable_i && evt_i.clk_fail |=> internal_osc_run_mode_o && flags[BIT_OSC_FAIL])
    else $error("clock fail not handled");

  // a flag read never shows the two bits with no flag behind them
  a_unimpl_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R10]
    $past(req_i.rd) && $past(req_i.addr) == OFS_EVENT_FLAGS |-> rdata_o[2] == 1'b0 && rdata_o[0] == 1'b0)
    else $error("unimplemented flag bit read nonzero");

  // master bit set: no pin of either port gets a pull-up
  a_pullup_off: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R02]
    ctrl[BIT_PULLUP_MASTER_DISABLE] |-> port_a_pullup_on_o == 8'h00 && port_b_pullup_on_o == 8'h00)
    else $error("pull-up active while master disable set");

  // rising selected: a low-to-high step on the first input is reported
  a_edge_rise: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R01]
    ctrl[BIT_EDGE0] && !$past(ext_irq_pin_i[0]) && ext_irq_pin_i[0] && !$past(srst_i)
    |-> ext_irq_event_o[0])
    else $error("rising edge missed");

  // a timer zero request goes to the level its priority bit names
  a_tmr0_prio: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R03]
    timer_zero_overflow_i |-> timer_zero_hi_prio_o == ctrl[BIT_TMR0_PRIO])
    else $error("timer zero priority wrong");

  // a port change request goes to the level its priority bit names
  a_port_prio: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R04]
    port_change_i |-> port_change_lo_prio_o != ctrl[BIT_PORT_CHG_PRIO])
    else $error("port change priority wrong");

  // a busy write cycle with time still left to run
  sequence s_nv_run;
    nv_state == NV_BUSY && nv_cnt != '0;
  endsequence

  // a start from idle loads the full write time
  a_nv_load: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R07]
    s_nv_start |=> nv_state == NV_BUSY && nv_cnt == CW'(NV_CYCLES - 1))
    else $error("write cycle did not load its time");

  // a start strobe while busy is refused: the count only runs down
  a_nv_refuse: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R09]
    s_nv_run |=> nv_state == NV_BUSY && nv_cnt == $past(nv_cnt) - CW'(1))
    else $error("busy write cycle disturbed");

  // once in the internal run mode the block stays there until reset
  a_run_sticky: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R06]
    internal_osc_run_mode_o |=> internal_osc_run_mode_o)
    else $error("internal run mode left without reset");

  // without the monitor a clock failure changes nothing
  a_osc_quiet: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R06]
    !fail_safe_enable_i && !internal_osc_run_mode_o |=> !internal_osc_run_mode_o)
    else $error("run mode entered with the monitor off");

  // master bit clear: a pin pulls up only as an input with its own bit set
  a_pullup_pin: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R02]
    !ctrl[BIT_PULLUP_MASTER_DISABLE]
    |-> port_a_pullup_on_o == (pu_a & port_a_input_mode_i)
    && port_b_pullup_on_o == (pu_b & port_b_input_mode_i))
    else $error("per-pin pull-up gating wrong");

  // no request in, nothing steered out on either level
  a_tmr0_idle: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R03]
    !timer_zero_overflow_i |-> !timer_zero_hi_prio_o && !timer_zero_lo_prio_o)
    else $error("timer zero steered without a request");
  a_port_idle: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R04]
    !port_change_i |-> !port_change_hi_prio_o && !port_change_lo_prio_o)
    else $error("port change steered without a request");

  // a pin that did not move since the last edge raises no event
  a_edge_quiet: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R01]
    ext_irq_pin_i == $past(ext_irq_pin_i) && !$past(srst_i) |-> ext_irq_event_o == '0)
    else $error("edge event without a pin change");

  // every input with falling selected reports a high-to-low step
  for (genvar p = 0; p < N_EXT; p++) begin : g_edge_chk
    a_edge_fall: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R01]
      !edge_sel[p] && $past(ext_irq_pin_i[p]) && !ext_irq_pin_i[p] && !$past(srst_i)
      |-> ext_irq_event_o[p])
      else $error("falling edge missed");
  end

  // per flag bit: its event sets it, only a zero write clears it,
  // and a bit with no flag behind it never reads as set
  for (genvar b = 0; b < 8; b++) begin : g_flag_chk
    if (FLAG_IMPL_MASK[b]) begin : g_impl
      a_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R05]
        evt_set[b] |=> flags[b])
        else $error("flag event did not set its bit");
      a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R10]
        wr_flags && !req_i.wdata[b] && !evt_set[b] |=> !flags[b])
        else $error("zero write did not clear its flag");
      a_flag_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R10]
        flags[b] && !(wr_flags && !req_i.wdata[b]) |=> flags[b])
        else $error("flag dropped without a zero write");
    end else begin : g_unimpl
      a_flag_unused: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [R10]
        !flags[b])
        else $error("unimplemented flag bit set");
    end
  end
endmodule // iepf_top

// ---- iepf_event_src.sv ----
// peripheral event source model standing beside the second flag register
// assumes the block's clock; fire_i requests one event pulse per bit
`timescale 1ns/1ps
module iepf_event_src
  import iepf_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [4:0] fire_i,
  output iepf_evt_t evt_o
);
  iepf_evt_t next_evt;
  // each request passes through one register, so a strobe lasts as long as its request
  always_comb begin
    next_evt = srst_i ? '0 : iepf_evt_t'(fire_i);
  end
  // strobes leave on the clock edge, never mid-cycle
  always_ff @(posedge ref_clk_i) begin
    evt_o <= next_evt;
  end
endmodule // iepf_event_src

// ---- interrupt_edge_priority_flags_bench.sv ----
// self-checking bench for edge/priority control and the second event flag register
// assumes the event source model, a 25 MHz clock and a short write time
`timescale 1ns/1ps
module interrupt_edge_priority_flags_bench;
  import iepf_pkg::*;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  iepf_req_t req = '0;
  logic [7:0] rdata, pua, pub, rd_v;
  logic [2:0] pins = 3'h0;
  logic [2:0] ev;
  logic [4:0] fire = 5'h00;
  iepf_evt_t evt;
  logic fs_en = 1'b0;
  logic tz = 1'b1;
  logic pc = 1'b1;
  // short write time; the nv timing check needs at least 4 cycles
  localparam int NV_T = 6;
  logic run_mode, t_hi, t_lo, p_hi, p_lo, irq;
  int fail_count = 0;
  int num_checks = 0;
  // clock
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  iepf_top #(.NV_CYCLES(NV_T)) u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(req),
    .rdata_o(rdata), .ext_irq_pin_i(pins), .ext_irq_event_o(ev), .evt_i(evt),
    .fail_safe_enable_i(fs_en), .timer_zero_overflow_i(tz), .port_change_i(pc),
    .port_a_input_mode_i(8'h33), .port_b_input_mode_i(8'h5A), .port_a_pullup_on_o(pua),
    .port_b_pullup_on_o(pub), .internal_osc_run_mode_o(run_mode),
    .timer_zero_hi_prio_o(t_hi), .timer_zero_lo_prio_o(t_lo),
    .port_change_hi_prio_o(p_hi), .port_change_lo_prio_o(p_lo), .irq_o(irq));
  iepf_event_src u_src (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .fire_i(fire), .evt_o(evt));
  // compare and count
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, want, seen);
    end
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    req.wr <= 1'b0;
    #1;
  endtask
  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    req.rd <= 1'b0;
    #1 rd_v = rdata;
  endtask
  // one peripheral event, k counts from clock failure down to timer overflow
  task automatic fire_evt(input int k);
    @(posedge ref_clk_i) fire <= 5'h10 >> k;
    @(posedge ref_clk_i) fire <= 5'h00;
  endtask
  // control values sweep edges, priorities, pull-up master and unused bits
  task automatic ctrl_scenario();
    logic [7:0] vals [4] = '{8'hFF, 8'h00, 8'hDB, 8'h26};
    logic [7:0] v;
    logic [2:0] r;
    wr(OFS_PULLUP_A, 8'h0F);
    wr(OFS_PULLUP_B, 8'hF0);
    for (int i = 0; i < 4; i++) begin
      v = vals[i];
      r = {v[BIT_EDGE2], v[BIT_EDGE1], v[BIT_EDGE0]};
      wr(OFS_EDGE_PRIO_CTRL, v);
      rd(OFS_EDGE_PRIO_CTRL);
      check("ctrl", rd_v, v & 8'hF5);
      check("pull_a", pua, v[7] ? 8'h00 : 8'h03);
      check("pull_b", pub, v[7] ? 8'h00 : 8'h50);
      check("prio", {4'h0, t_hi, t_lo, p_hi, p_lo}, {4'h0, v[2], !v[2], v[0], !v[0]});
      @(posedge ref_clk_i) pins <= 3'h7;
      #1 check("rise", {5'h00, ev}, {5'h00, r});
      @(posedge ref_clk_i) pins <= 3'h0;
      #1 check("fall", {5'h00, ev}, {5'h00, ~r});
    end
    // with no requests in, no priority output may rise
    @(posedge ref_clk_i) begin
      tz <= 1'b0;
      pc <= 1'b0;
    end
    #1 check("prio_idle", {4'h0, t_hi, t_lo, p_hi, p_lo}, 8'h00);
  endtask
  // events latch with mask clear, then mask, keep-on-one and clear-on-zero
  task automatic event_scenario();
    int pos [5] = '{7, 6, 5, 3, 1};
    logic [7:0] acc;
    acc = 8'h00;
    fire_evt(0);
    rd(OFS_EVENT_FLAGS);
    check("no_monitor", rd_v, 8'h00);
    check("no_run", {7'h00, run_mode}, 8'h00);
    @(posedge ref_clk_i) fs_en <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      fire_evt(k);
      acc[pos[k]] = 1'b1;
      rd(OFS_EVENT_FLAGS);
      check("flags", rd_v, acc);
      check("irq_masked", {7'h00, irq}, 8'h00);
    end
    rd(OFS_STATUS);
    check("status", rd_v, 8'h01);
    check("run_mode", {7'h00, run_mode}, 8'h01);
    wr(OFS_EVENT_MASK, 8'h02);
    check("irq_on", {7'h00, irq}, 8'h01);
    wr(OFS_EVENT_FLAGS, 8'hFF);
    rd(OFS_EVENT_FLAGS);
    check("keep", rd_v, 8'hEA);
    wr(OFS_EVENT_FLAGS, 8'hF7);
    rd(OFS_EVENT_FLAGS);
    check("clear_one", rd_v, 8'hE2);
    wr(OFS_EVENT_FLAGS, 8'h00);
    check("irq_off", {7'h00, irq}, 8'h00);
  endtask
  // nonvolatile write cycle ends with busy low and done flag set
  task automatic nv_scenario();
    int n;
    n = 0;
    wr(OFS_EVENT_MASK, 8'h10);
    wr(OFS_NV_CTRL, 8'h01);
    rd(OFS_STATUS);
    check("busy", rd_v, 8'h03);
    // a second start while busy is refused and must not stretch the write
    wr(OFS_NV_CTRL, 8'h01);
    while (irq !== 1'b1 && n < 40) begin
      @(posedge ref_clk_i);
      #1 n = n + 1;
    end
    if (n >= 40) begin
      fail_count++;
    end else begin
      check("nv_time", n[7:0], 8'(NV_T - 4));
      rd(OFS_EVENT_FLAGS);
      check("done", rd_v, 8'h10);
      rd(OFS_STATUS);
      check("idle", rd_v, 8'h01);
      wr(OFS_EVENT_FLAGS, 8'h00);
      check("done_clr", {7'h00, irq}, 8'h00);
    end
  endtask
  // reset, reset values, then the scenarios
  initial begin
    repeat (5) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd(OFS_EDGE_PRIO_CTRL);
    check("ctrl_rst", rd_v, 8'hF5);
    rd(OFS_EVENT_FLAGS);
    check("flags_rst", rd_v, 8'h00);
    rd(4'h7);
    check("unmapped", rd_v, 8'h00);
    ctrl_scenario();
    event_scenario();
    nv_scenario();
    tally_and_finish();
  end
endmodule // interrupt_edge_priority_flags_bench
